// *** shared/gpct_regs.vh ***
// Register map, field positions, reset values and timing for the timer
`ifndef GPCT_REGS_VH
`define GPCT_REGS_VH

// Register byte addresses
`define GPCT_ADDR_RELOAD      32'hffff0320
`define GPCT_ADDR_COUNT       32'hffff0324
`define GPCT_ADDR_CONTROL     32'hffff0328
`define GPCT_ADDR_ICLR        32'hffff032c
`define GPCT_ADDR_CAPTURE     32'hffff0330
`define GPCT_ADDR_IRQ_STATUS  32'hffff0334
`define GPCT_ADDR_IRQ_MASK    32'hffff0338

// Control fields
`define GPCT_CTL_PRESC_LSB    0
`define GPCT_CTL_PRESC_MSB    3
`define GPCT_CTL_FMT_LSB      4
`define GPCT_CTL_FMT_MSB      5
`define GPCT_CTL_PERIODIC     6
`define GPCT_CTL_ENABLE       7
`define GPCT_CTL_COUNT_UP     8
`define GPCT_CTL_SRC_LSB      9
`define GPCT_CTL_SRC_MSB      11
`define GPCT_CTL_EVT_LSB      12
`define GPCT_CTL_EVT_MSB      16
`define GPCT_CTL_CAP_EN       17
`define GPCT_CTL_WIDTH        18

// Clock sources
`define GPCT_SRC_CORE         3'h0
`define GPCT_SRC_OSC          3'h1
`define GPCT_SRC_GPIO_A       3'h2
`define GPCT_SRC_GPIO_B       3'h3

// Count formats
`define GPCT_FMT_BINARY       2'h0
`define GPCT_FMT_HMS_23       2'h2
`define GPCT_FMT_HMS_255      2'h3

// Time format field limits
`define GPCT_HUND_MAX         8'h63
`define GPCT_SEC_MAX          8'h3b
`define GPCT_HOUR_MAX_23      8'h17
`define GPCT_HOUR_MAX_255     8'hff

// Interrupt status bits
`define GPCT_IRQ_TIMEOUT      0
`define GPCT_IRQ_CAPTURE      1
`define GPCT_IRQ_WIDTH        2

// Reset values
`define GPCT_RST_RELOAD       32'h00000000
`define GPCT_RST_COUNT        32'h00000000
`define GPCT_RST_CONTROL      18'h00000
`define GPCT_RST_CAPTURE      32'h00000000

// Prescaler counter width covers the largest divide of 32768
`define GPCT_PRESC_CNT_W      15

`endif

// *** hw/gpct_prescaler.v ***
// Clock source selection, synchronisation and prescaled count tick
`timescale 1ns/1ps
`default_nettype none
`include "gpct_regs.vh"

module gpct_prescaler #(
    parameter CNT_W = `GPCT_PRESC_CNT_W
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Configuration
    input  wire [2:0] src_sel,
    input  wire [3:0] presc,
    input  wire       enable,
    input  wire       low_power,
    // Raw sources
    input  wire       osc_in,
    input  wire       gpio_a_in,
    input  wire       gpio_b_in,
    // Count enable
    output reg        tick
);

    reg  [2:0]       meta_r;
    reg  [2:0]       sync_r;
    reg  [2:0]       last_r;
    reg  [CNT_W-1:0] div_r;
    reg              src_edge;
    wire [CNT_W-1:0] div_top;
    wire [2:0]       rise;

    assign div_top = {CNT_W{1'b1}} >> (CNT_W - {1'b0, presc});
    assign rise    = sync_r & ~last_r;

    // Two-flop synchronisers, edge seen from second stage onward
    always @(posedge clk or negedge rst_n) begin // [RQ18]
        if (!rst_n) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            last_r <= 3'h0;
        end else begin
            meta_r <= {gpio_b_in, gpio_a_in, osc_in};
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Core clock stops in low power; external sources keep going
    always @* begin // [RQ2] [RQ11]
        case (src_sel)
            `GPCT_SRC_CORE:   src_edge = ~low_power;
            `GPCT_SRC_OSC:    src_edge = rise[0];
            `GPCT_SRC_GPIO_A: src_edge = rise[1];
            `GPCT_SRC_GPIO_B: src_edge = rise[2];
            default:          src_edge = 1'b0;
        endcase
    end

    // Divide by two to the power of the prescaler code
    always @(posedge clk or negedge rst_n) begin // [RQ3]
        if (!rst_n) begin
            div_r <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (!enable) begin
            div_r <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (src_edge) begin
            if (div_r >= div_top) begin
                div_r <= {CNT_W{1'b0}};
                tick  <= 1'b1;
            end else begin
                div_r <= div_r + 1'b1;
                tick  <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // gpct_prescaler
`default_nettype wire

// *** hw/gpct_timer.v ***
// General-purpose capture timer with AHB-Lite register slave
//
// Summary of operation
// RQ1 - Counter counts up when direction bit set, down when cleared (default).
// RQ2 - Source field picks core clock, oscillator, GPIO input A or B.
// RQ3 - Prescaler divides the chosen source by 1, 16, 256 or 32768.
// RQ4 - Timer counts only while its enable bit is set; off after reset.
// RQ5 - Mode bit selects periodic when set, free-running when cleared.
// RQ6 - Format field picks binary, or time format to 23 or 255 hours.
// RQ7 - Capture-enable bit and five-bit event code choose capture trigger.
// RQ8 - First assertion of selected source copies count into capture register.
// RQ9 - Counter reloads from load value on overflow and on clear write; code reloads on overflow only in periodic mode.
// RQ10 - Any write to the clear register clears the pending timer interrupt.
// RQ11 - In low power, oscillator or GPIO clocked timer keeps running.
// RQ12 - Value register always reads the live counter.
// RQ13 - Software writes zeros to control bits 31 to 18.
// RQ14 - Free-running counter restarts from full scale or zero after wrap.
// RQ15 - Periodic counter restarts from load value after wrap.
// RQ16 - Interrupt raised each time count reaches zero or full scale.
// RQ17 - Event codes map to system interrupt sources, lines 0 to 17.
// RQ18 - External sources are synchronised; prescaled tick enables the counter.
// RQ19 - Time formats pack hundredths, seconds, minutes, hours, each wrapping.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpct_regs.vh"

module gpct_timer #(
    parameter NUM_EVT = 32
) (
    // Clock and reset
    input  wire               CLK_SYS,
    input  wire               RST_N,
    // AHB-Lite slave
    input  wire               HSEL,
    input  wire [31:0]        HADDR,
    input  wire [1:0]         HTRANS,
    input  wire               HWRITE,
    input  wire [2:0]         HSIZE,
    input  wire [31:0]        HWDATA,
    input  wire               HREADY,
    output reg  [31:0]        HRDATA,
    output reg                HREADYOUT,
    output reg                HRESP,
    // Clock sources
    input  wire               OSC_32K,
    input  wire               GPIO_CLK_A,
    input  wire               GPIO_CLK_B,
    input  wire               LOW_POWER,
    // Capture event lines, indexed by event code
    input  wire [NUM_EVT-1:0] EVENT_LINES,
    // Interrupt
    output reg                TIMER_IRQ
);

    reg  [31:0]                  reload_r;
    reg  [31:0]                  count_r;
    reg  [31:0]                  count_nxt;
    reg  [`GPCT_CTL_WIDTH-1:0]   ctrl_r;
    reg  [31:0]                  capture_r;
    reg  [`GPCT_IRQ_WIDTH-1:0]   status_r;
    reg  [`GPCT_IRQ_WIDTH-1:0]   status_nxt;
    reg  [`GPCT_IRQ_WIDTH-1:0]   mask_r;
    reg  [NUM_EVT-1:0]           evt_last_r;
    reg                          dph_wr_r;
    reg  [31:0]                  dph_addr_r;
    reg  [31:0]                  rd_mux;
    reg                          wrap;

    wire                         tick;
    wire                         addr_ok;
    wire                         wr_en;
    wire                         iclr_wr;
    wire                         status_wr;
    wire [1:0]                   fmt;
    wire                         up;
    wire [31:0]                  full;
    wire [31:0]                  term;
    wire [4:0]                   evt_sel;
    wire [NUM_EVT-1:0]           evt_edge;
    wire                         evt_rise;
    wire                         cap_hit;

    // Largest count for the format in use
    function [31:0] full_scale;
        input [1:0] f;
        begin
            case (f)
                `GPCT_FMT_HMS_23:
                    full_scale = {`GPCT_HOUR_MAX_23, `GPCT_SEC_MAX,
                                  `GPCT_SEC_MAX, `GPCT_HUND_MAX};
                `GPCT_FMT_HMS_255:
                    full_scale = {`GPCT_HOUR_MAX_255, `GPCT_SEC_MAX,
                                  `GPCT_SEC_MAX, `GPCT_HUND_MAX};
                default:
                    full_scale = 32'hffffffff;
            endcase
        end
    endfunction

    // Field-wise increment of packed time value
    function [31:0] hms_inc;
        input [31:0] v;
        input [7:0]  hmax;
        reg   [7:0]  hs;
        reg   [7:0]  s;
        reg   [7:0]  m;
        reg   [7:0]  h;
        begin
            hs = v[7:0];
            s  = v[15:8];
            m  = v[23:16];
            h  = v[31:24];
            if (hs < `GPCT_HUND_MAX) begin // [RQ19]
                hs = hs + 8'h01;
            end else begin
                hs = 8'h00;
                if (s < `GPCT_SEC_MAX) begin
                    s = s + 8'h01;
                end else begin
                    s = 8'h00;
                    if (m < `GPCT_SEC_MAX) begin
                        m = m + 8'h01;
                    end else begin
                        m = 8'h00;
                        h = (h < hmax) ? h + 8'h01 : 8'h00;
                    end
                end
            end
            hms_inc = {h, m, s, hs};
        end
    endfunction

    // Field-wise decrement of packed time value
    function [31:0] hms_dec;
        input [31:0] v;
        input [7:0]  hmax;
        reg   [7:0]  hs;
        reg   [7:0]  s;
        reg   [7:0]  m;
        reg   [7:0]  h;
        begin
            hs = v[7:0];
            s  = v[15:8];
            m  = v[23:16];
            h  = v[31:24];
            if (hs != 8'h00) begin // [RQ19]
                hs = hs - 8'h01;
            end else begin
                hs = `GPCT_HUND_MAX;
                if (s != 8'h00) begin
                    s = s - 8'h01;
                end else begin
                    s = `GPCT_SEC_MAX;
                    if (m != 8'h00) begin
                        m = m - 8'h01;
                    end else begin
                        m = `GPCT_SEC_MAX;
                        h = (h != 8'h00) ? h - 8'h01 : hmax;
                    end
                end
            end
            hms_dec = {h, m, s, hs};
        end
    endfunction

    // Write strobe for one register in its data phase
    function wr_hit;
        input        we;
        input [31:0] a;
        input [31:0] r;
        begin
            wr_hit = we & (a == r);
        end
    endfunction

    assign fmt     = ctrl_r[`GPCT_CTL_FMT_MSB:`GPCT_CTL_FMT_LSB];
    assign up      = ctrl_r[`GPCT_CTL_COUNT_UP];
    assign full    = full_scale(fmt);
    assign term    = up ? full : 32'h00000000;
    assign evt_sel = ctrl_r[`GPCT_CTL_EVT_MSB:`GPCT_CTL_EVT_LSB];

    gpct_prescaler #(
        .CNT_W     (`GPCT_PRESC_CNT_W)
    ) u_presc (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .src_sel   (ctrl_r[`GPCT_CTL_SRC_MSB:`GPCT_CTL_SRC_LSB]),
        .presc     (ctrl_r[`GPCT_CTL_PRESC_MSB:`GPCT_CTL_PRESC_LSB]),
        .enable    (ctrl_r[`GPCT_CTL_ENABLE]),
        .low_power (LOW_POWER),
        .osc_in    (OSC_32K),
        .gpio_a_in (GPIO_CLK_A),
        .gpio_b_in (GPIO_CLK_B),
        .tick      (tick)
    );

    // Bus address and data phase
    assign addr_ok   = HSEL & HTRANS[1] & HREADY;
    assign wr_en     = dph_wr_r;
    assign iclr_wr   = wr_hit(wr_en, dph_addr_r, `GPCT_ADDR_ICLR);
    assign status_wr = wr_hit(wr_en, dph_addr_r, `GPCT_ADDR_IRQ_STATUS);

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 32'h00000000;
        end else begin
            dph_wr_r   <= addr_ok & HWRITE;
            dph_addr_r <= HADDR;
        end
    end

    // Read data latched at the address phase; unmapped reads as zero
    always @* begin
        case (HADDR)
            `GPCT_ADDR_RELOAD:     rd_mux = reload_r;
            `GPCT_ADDR_COUNT:      rd_mux = count_r; // [RQ12]
            `GPCT_ADDR_CONTROL:    rd_mux = {14'h0000, ctrl_r};
            `GPCT_ADDR_CAPTURE:    rd_mux = capture_r;
            `GPCT_ADDR_IRQ_STATUS: rd_mux = {30'h00000000, status_r};
            `GPCT_ADDR_IRQ_MASK:   rd_mux = {30'h00000000, mask_r};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA    <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (addr_ok & ~HWRITE) begin
                HRDATA <= rd_mux;
            end
        end
    end

    // Software registers; upper control bits are not stored
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            reload_r <= `GPCT_RST_RELOAD;
            ctrl_r   <= `GPCT_RST_CONTROL;
            mask_r   <= {`GPCT_IRQ_WIDTH{1'b0}};
        end else if (wr_en) begin
            if (dph_addr_r == `GPCT_ADDR_RELOAD) begin
                reload_r <= HWDATA;
            end
            if (dph_addr_r == `GPCT_ADDR_CONTROL) begin
                ctrl_r <= HWDATA[`GPCT_CTL_WIDTH-1:0]; // [RQ13]
            end
            if (dph_addr_r == `GPCT_ADDR_IRQ_MASK) begin
                mask_r <= HWDATA[`GPCT_IRQ_WIDTH-1:0];
            end
        end
    end

    // Counter next value
    always @* begin
        count_nxt = count_r;
        wrap      = 1'b0;
        // Clear write wins over a tick in the same cycle
        if (iclr_wr) begin
            count_nxt = reload_r; // [RQ9]
        end else if (ctrl_r[`GPCT_CTL_ENABLE] && tick) begin // [RQ4] [RQ18]
            if (count_r == term) begin // [RQ16]
                wrap = 1'b1;
                if (ctrl_r[`GPCT_CTL_PERIODIC]) begin // [RQ5]
                    count_nxt = reload_r; // [RQ15] [RQ9]
                end else begin
                    count_nxt = up ? 32'h00000000 : full; // [RQ14]
                end
            end else if (fmt[1]) begin // [RQ6]
                count_nxt = up ? hms_inc(count_r, full[31:24])
                               : hms_dec(count_r, full[31:24]);
            end else begin
                count_nxt = up ? count_r + 32'h00000001 // [RQ1]
                               : count_r - 32'h00000001;
            end
        end
    end

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            count_r <= `GPCT_RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Per-line rising edges; lines idle low, history resets low
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_evt
            assign evt_edge[gi] = EVENT_LINES[gi] & ~evt_last_r[gi];
        end
    endgenerate

    // Capture on the rising edge of the selected event line
    assign evt_rise = evt_edge[evt_sel]; // [RQ17]
    assign cap_hit  = ctrl_r[`GPCT_CTL_CAP_EN] & evt_rise; // [RQ7]

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            evt_last_r <= {NUM_EVT{1'b0}};
            capture_r  <= `GPCT_RST_CAPTURE;
        end else begin
            evt_last_r <= EVENT_LINES;
            if (cap_hit) begin
                capture_r <= count_r; // [RQ8]
            end
        end
    end

    // Sticky status: write one clears, new event wins over clear
    always @* begin
        status_nxt = status_r;
        if (status_wr) begin
            status_nxt = status_r & ~HWDATA[`GPCT_IRQ_WIDTH-1:0];
        end
        if (iclr_wr) begin
            status_nxt[`GPCT_IRQ_TIMEOUT] = 1'b0; // [RQ10]
        end
        if (wrap) begin
            status_nxt[`GPCT_IRQ_TIMEOUT] = 1'b1; // [RQ16]
        end
        if (cap_hit) begin
            status_nxt[`GPCT_IRQ_CAPTURE] = 1'b1;
        end
    end

    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            status_r  <= {`GPCT_IRQ_WIDTH{1'b0}};
            TIMER_IRQ <= 1'b0;
        end else begin
            status_r  <= status_nxt;
            TIMER_IRQ <= |(status_r & mask_r);
        end
    end

endmodule // gpct_timer
`default_nettype wire

// *** bench/gpct_timer_properties.sv ***
// Port checker for the capture timer
`timescale 1ns/1ps
`default_nettype none
`include "gpct_regs.vh"

module gpct_checker #(
    parameter NUM_EVT = 32
) (
    // Clock and reset
    input wire logic               CLK_SYS,
    input wire logic               RST_N,
    // Register bus
    input wire logic               HSEL,
    input wire logic [31:0]        HADDR,
    input wire logic [1:0]         HTRANS,
    input wire logic               HWRITE,
    input wire logic [31:0]        HWDATA,
    input wire logic               HREADY,
    input wire logic [31:0]        HRDATA,
    input wire logic               HREADYOUT,
    input wire logic               HRESP,
    // Events and interrupt
    input wire logic [NUM_EVT-1:0] EVENT_LINES,
    input wire logic               TIMER_IRQ
);
    logic               dp_wr_r;
    logic               dp_rd_r;
    logic               rl_ok_r;
    logic [31:0]        dp_a_r;
    logic [31:0]        ld_r;
    logic [17:0]        ctl_r;
    logic [1:0]         mask_r;
    logic [NUM_EVT-1:0] ev_r;
    wire                wdone = dp_wr_r && HREADY;
    wire  [4:0]         sel = ctl_r[16:12];
    wire                rise = EVENT_LINES[sel] && !ev_r[sel];

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // Shadow of the software-visible settings
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            rl_ok_r <= 1'b0;
            dp_a_r <= 32'h0;
            ld_r <= 32'h0;
            ctl_r <= 18'h0;
            mask_r <= 2'h0;
            ev_r <= '0;
        end else begin
            ev_r <= EVENT_LINES;
            if (HREADY) begin
                dp_wr_r <= HSEL && HTRANS[1] && HWRITE;
                dp_rd_r <= HSEL && HTRANS[1] && !HWRITE;
                dp_a_r <= HADDR;
            end
            if (wdone) begin
                rl_ok_r <= dp_a_r == `GPCT_ADDR_ICLR && !ctl_r[7];
                if (dp_a_r == `GPCT_ADDR_CONTROL)
                    ctl_r <= HWDATA[17:0];
                if (dp_a_r == `GPCT_ADDR_RELOAD)
                    ld_r <= HWDATA;
                if (dp_a_r == `GPCT_ADDR_IRQ_MASK)
                    mask_r <= HWDATA[1:0];
            end
        end
    end

    property p_ready;
        dp_rd_r |-> HREADYOUT;
    endproperty
    property p_ctl_rb;
        dp_rd_r && dp_a_r == `GPCT_ADDR_CONTROL && !$past(dp_wr_r)
            |-> HRDATA == {14'h0, ctl_r};
    endproperty
    property p_ld_rb;
        dp_rd_r && dp_a_r == `GPCT_ADDR_RELOAD && !$past(dp_wr_r)
            |-> HRDATA == ld_r;
    endproperty
    property p_reload_clear;
        dp_rd_r && dp_a_r == `GPCT_ADDR_COUNT && rl_ok_r && $past(rl_ok_r)
            |-> HRDATA == ld_r;
    endproperty
    property p_iclr_clears;
        wdone && dp_a_r == `GPCT_ADDR_ICLR && !mask_r[1] |-> ##2 !TIMER_IRQ;
    endproperty
    property p_okay;
        dp_rd_r || dp_wr_r |-> !HRESP;
    endproperty
    property p_masked_quiet;
        mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !TIMER_IRQ;
    endproperty
    property p_irq_hold;
        TIMER_IRQ && !wdone && !$past(wdone) |=> TIMER_IRQ;
    endproperty
    property p_capture_irq;
        rise && ctl_r[17] && mask_r[1] |-> ##[1:2] TIMER_IRQ;
    endproperty

    a_ready: assert property (p_ready)
        else $error("bus wait state seen");
    a_okay: assert property (p_okay)
        else $error("bus error response seen");
    a_ctl_rb: assert property (p_ctl_rb)
        else $error("control read back differs");
    a_ld_rb: assert property (p_ld_rb)
        else $error("reload read back differs");
    a_reload_clear: assert property (p_reload_clear)
        else $error("count not reloaded by clear write");
    a_iclr_clears: assert property (p_iclr_clears)
        else $error("interrupt still high after clear write");
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt high while fully masked");
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without a write");
    a_capture_irq: assert property (p_capture_irq)
        else $error("capture event raised no interrupt");

    c_wrap: cover property (TIMER_IRQ && mask_r == 2'h1);
    c_capture: cover property (rise && ctl_r[17]);
    c_reload: cover property (dp_rd_r && rl_ok_r);
endmodule // gpct_checker

bind gpct_timer gpct_checker #(.NUM_EVT(NUM_EVT)) gpct_checker_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .EVENT_LINES(EVENT_LINES),
    .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

// *** bench/gpct_tb.sv ***
// Self-checking testbench for the capture timer
`timescale 1ns/1ps
`default_nettype none
`include "gpct_regs.vh"

module tb;
    localparam logic [31:0] A_LD = `GPCT_ADDR_RELOAD;
    localparam logic [31:0] A_CNT = `GPCT_ADDR_COUNT;
    localparam logic [31:0] A_CTL = `GPCT_ADDR_CONTROL;
    localparam logic [31:0] A_CLR = `GPCT_ADDR_ICLR;
    localparam logic [31:0] A_CAP = `GPCT_ADDR_CAPTURE;
    localparam logic [31:0] A_ST = `GPCT_ADDR_IRQ_STATUS;
    localparam logic [31:0] A_MSK = `GPCT_ADDR_IRQ_MASK;
    localparam logic [31:0] A_NONE = 32'hffff033c;
    // Design signals
    logic        CLK_SYS = 1'b0;
    logic        RST_N = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        OSC_32K = 1'b0;
    logic        GPIO_CLK_A = 1'b0;
    logic        GPIO_CLK_B = 1'b0;
    logic        LOW_POWER = 1'b0;
    logic [31:0] EVENT_LINES = 32'h0;
    logic        TIMER_IRQ;
    // Bench state
    logic        rd_dp = 1'b0;
    logic        irq_chk = 1'b0;
    logic [31:0] exp_rd[$];
    logic        exp_irq[$];
    logic [31:0] seed = 32'hc0e86e24;
    int          n_mismatch = 0;
    int          n_compared = 0;
    // Clocked scenarios: control, line, load, pulses, count, wrap
    logic [31:0] t_ctl[14] = '{32'h4c0, 32'h580, 32'h480, 32'h4a0, 32'h4b0,
        32'h5a0, 32'h5c0, 32'h490, 32'h484, 32'h488, 32'h680, 32'h280,
        32'h080, 32'h400};
    logic [2:0]  t_ln[14] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 4, 1, 1};
    logic [31:0] t_ld[14] = '{3, 32'hfffffffe, 0, 0, 0, 32'h003b3b63,
        32'hfffffffe, 5, 100, 100, 5, 5, 5, 5};
    int          t_n[14] = '{4, 2, 1, 1, 1, 1, 2, 1, 32, 256, 1, 1, 1, 1};
    logic [31:0] t_ex[14] = '{3, 0, 32'hffffffff, 32'h173b3b63,
        32'hff3b3b63, 32'h01000000, 32'hfffffffe, 4, 98, 99, 4, 4, 5, 5};
    logic        t_wr[14] = '{1, 1, 1, 1, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0};

    always #10 CLK_SYS = ~CLK_SYS;

    gpct_timer #(.NUM_EVT(32)) gpct_timer_i (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .OSC_32K(OSC_32K), .GPIO_CLK_A(GPIO_CLK_A),
        .GPIO_CLK_B(GPIO_CLK_B), .LOW_POWER(LOW_POWER),
        .EVENT_LINES(EVENT_LINES), .TIMER_IRQ(TIMER_IRQ));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge CLK_SYS);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rd_dp <= !wr;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic chk_irq(input logic e);
        exp_irq.push_back(e);
        @(posedge CLK_SYS);
        irq_chk <= 1'b1;
        @(posedge CLK_SYS);
        irq_chk <= 1'b0;
    endtask

    // Rising edges on one clock source line
    task automatic pulse(input logic [2:0] ln, input int n);
        repeat (n) begin
            repeat (4) @(posedge CLK_SYS);
            {OSC_32K, GPIO_CLK_B, GPIO_CLK_A} <= ln;
            repeat (4) @(posedge CLK_SYS);
            {OSC_32K, GPIO_CLK_B, GPIO_CLK_A} <= 3'h0;
        end
        repeat (8) @(posedge CLK_SYS);
    endtask

    task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_irq(input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge CLK_SYS) begin
        if (rd_dp && HREADYOUT === 1'b1)
            cmp_data(exp_rd.pop_front(), HRDATA);
        if (irq_chk)
            cmp_irq(exp_irq.pop_front(), TIMER_IRQ);
    end

    initial begin
        repeat (50000) @(posedge CLK_SYS);
        n_mismatch++;
        final_report();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] cap;
        logic [4:0]  code;
        logic [31:0] ra[7];
        ra = '{A_LD, A_CNT, A_CTL, A_CAP, A_ST, A_MSK, A_NONE};
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(ra[i], 32'h0);
        v = rnd() & 32'hffffff7f;
        wr(A_CTL, v | 32'hfffc0000);
        rd(A_CTL, v & 32'h0003ffff);
        for (int i = 0; i < 3; i++) begin
            wr(ra[3 * i + 1 - i], rnd());
        end
        rd(A_CNT, 32'h0);
        rd(A_NONE, 32'h0);
        wr(A_MSK, 32'h1);
        LOW_POWER <= 1'b1;
        for (int r = 0; r < 14; r++) begin
            wr(A_CTL, 32'h0);
            wr(A_LD, t_ld[r]);
            wr(A_ST, 32'h3);
            wr(A_CLR, rnd());
            rd(A_CNT, t_ld[r]);
            rd(A_LD, t_ld[r]);
            wr(A_CTL, t_ctl[r]);
            pulse(t_ln[r], t_n[r]);
            rd(A_CNT, t_ex[r]);
            rd(A_ST, {31'h0, t_wr[r]});
            chk_irq(t_wr[r]);
            wr(A_CLR, rnd());
            rd(A_ST, 32'h0);
            chk_irq(1'b0);
        end
        LOW_POWER <= 1'b0;
        wr(A_MSK, 32'h3);
        cap = 32'h0;
        for (int i = 0; i < 4; i++) begin
            code = 5'(rnd() % 18);
            v = rnd();
            wr(A_CTL, 32'h0);
            wr(A_LD, v);
            wr(A_CLR, 32'h0);
            wr(A_ST, 32'h3);
            wr(A_CTL, {14'h0, i < 3, code, 12'h0});
            EVENT_LINES <= 32'h1 << ((code + 5'h1) % 5'd18);
            repeat (4) @(posedge CLK_SYS);
            rd(A_CAP, cap);
            EVENT_LINES <= EVENT_LINES | (32'h1 << code);
            if (i < 3)
                cap = v;
            repeat (4) @(posedge CLK_SYS);
            rd(A_CAP, cap);
            rd(A_ST, {30'h0, i < 3, 1'b0});
            chk_irq(i < 3);
            EVENT_LINES <= 32'h0;
        end
        final_report();
    end
endmodule // tb
`default_nettype wire
